//--- hw/ccsr_cfg.svh
// Purpose: Constants for the clock and alignment control register bank.
// Assumes: Byte-wide registers at byte offsets of the serial register map.
// Notes: Shared by the register bank and its position store.
`ifndef CCSR_CFG_SVH
`define CCSR_CFG_SVH
`define CCSR_ADDR_W 15
`define CCSR_OFS_CTRL0 15'h0029
`define CCSR_OFS_CTRL1 15'h002a
`define CCSR_OFS_CTRL2 15'h002b
`define CCSR_OFS_POS0 15'h002c
`define CCSR_OFS_POS1 15'h002d
`define CCSR_OFS_POS2 15'h002e
`define CCSR_RST_CTRL0 8'h80
`define CCSR_RST_CTRL1 8'h00
`define CCSR_RST_CTRL2 8'h10
`define CCSR_RST_POS 24'h00_0000
`define CCSR_BIT_PROC_EN 6
`define CCSR_BIT_RECV_EN 5
`define CCSR_BIT_FINE 4
`define CCSR_SEL_HI 3
`define CCSR_SEL_LO 0
`define CCSR_BIT_INVERT 0
`define CCSR_BIT_ALIGN_PECL 1
`define CCSR_BIT_DEV_PECL 2
`define CCSR_BIT_ANA_SUPPR 2
`define CCSR_BIT_CLK_SUPPR 0
`define CCSR_ZERO8 8'h00
`endif

//--- hw/ccsr_pkg.sv
// Purpose: Types for the clock and alignment control register bank.
// Assumes: Nothing beyond the constants header.
// Notes: Only types live here.
package ccsr_pkg;
  typedef logic [7:0] ccsr_byte_t;
  typedef logic [23:0] ccsr_pos_t;
  typedef logic [3:0] ccsr_sel_t;
endpackage : ccsr_pkg

//--- hw/ccsr_pos_store.sv
// Purpose: Holds the captured alignment edge position for readback.
// Assumes: Capture strobe is one cycle wide and synchronous to clk.
// Notes: Read data comes out of a register, one cycle after the index.
`timescale 1ns/1ns
`include "ccsr_cfg.svh"
module ccsr_pos_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Capture side
  input wire logic cap_valid,
  input wire ccsr_pkg::ccsr_pos_t cap_value,
  // Read side
  input wire logic [1:0] rd_index,
  output ccsr_pkg::ccsr_byte_t rd_byte
);
  ccsr_pkg::ccsr_pos_t pos_r;
  ccsr_pkg::ccsr_byte_t rd_byte_r;
  wire ccsr_pkg::ccsr_byte_t sel_byte;

  assign sel_byte = (rd_index == 2'h0) ? pos_r[7:0] :
                    (rd_index == 2'h1) ? pos_r[15:8] :
                    (rd_index == 2'h2) ? pos_r[23:16] : `CCSR_ZERO8;
  assign rd_byte = rd_byte_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      pos_r <= `CCSR_RST_POS;
      rd_byte_r <= `CCSR_ZERO8;
    end else begin
      if (cap_valid) begin
        pos_r <= cap_value;
      end
      rd_byte_r <= sel_byte;
    end
  end
endmodule : ccsr_pos_store

//--- hw/ccsr_regs.sv
// Purpose: Clock and alignment control register bank of the converter.
// Assumes: A serial port front end gives one-cycle read and write strobes.
// Notes: Read data is registered and valid two cycles after the read strobe.
// What this block does
// - Processor enable bit 6 gates alignment events; cleared means ignored.
// - Bit 5 enables the alignment receiver circuit; resets disabled.
// - Bits 3:0 pick the applied delay, chosen from captured position.
// - Control one bit 0 inverts the alignment pulse before use.
// - Control one bit 2 puts the sample clock input in PECL mode.
// - Control one bit 1 puts the alignment input in PECL mode.
// - Control two bit 2 enables analog quiet supply noise suppression.
// - Control two bit 0 enables clock supply noise suppression.
// - Reset loads 0x80, 0x00 and 0x10 into the three registers.
// - A 24-bit read-only value reports the captured edge position.
`timescale 1ns/1ns
`include "ccsr_cfg.svh"
module ccsr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`CCSR_ADDR_W-1:0] reg_addr,
  input wire ccsr_pkg::ccsr_byte_t reg_wdata,
  output ccsr_pkg::ccsr_byte_t reg_rdata,
  output logic reg_rvalid,
  // Alignment pulse path
  input wire logic align_pulse_in,
  input wire logic pos_capture_valid,
  input wire ccsr_pkg::ccsr_pos_t pos_capture_value,
  output logic align_event,
  // Analog controls
  output logic align_receiver_enable,
  output logic align_processor_enable,
  output logic align_window_fine_steps,
  output ccsr_pkg::ccsr_sel_t align_delay_select,
  output logic align_polarity_invert,
  output logic device_clock_pecl_mode,
  output logic align_input_pecl_mode,
  output logic analog_rail_noise_suppress,
  output logic clock_rail_noise_suppress
);
  ccsr_pkg::ccsr_byte_t clock_control_zero_r;
  ccsr_pkg::ccsr_byte_t clock_control_one_r;
  ccsr_pkg::ccsr_byte_t clock_control_two_r;
  ccsr_pkg::ccsr_byte_t rdata_r;
  ccsr_pkg::ccsr_byte_t ctrl_rdata_r;
  logic rvalid_r;
  logic pos_sel_r;
  logic event_r;
  logic pulse_d_r;
  logic [1:0] pos_index;
  ccsr_pkg::ccsr_byte_t pos_byte;

  function automatic logic hit(input logic [`CCSR_ADDR_W-1:0] a,
                               input logic [`CCSR_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction : hit

  wire logic hit0 = hit(reg_addr, `CCSR_OFS_CTRL0);
  wire logic hit1 = hit(reg_addr, `CCSR_OFS_CTRL1);
  wire logic hit2 = hit(reg_addr, `CCSR_OFS_CTRL2);
  wire logic hitp0 = hit(reg_addr, `CCSR_OFS_POS0);
  wire logic hitp1 = hit(reg_addr, `CCSR_OFS_POS1);
  wire logic hitp2 = hit(reg_addr, `CCSR_OFS_POS2);
  wire logic hit_pos = hitp0 | hitp1 | hitp2;
  // Unmapped addresses read as zero so stray reads stay harmless.
  wire ccsr_pkg::ccsr_byte_t ctrl_sel =
    hit0 ? clock_control_zero_r :
    hit1 ? clock_control_one_r :
    hit2 ? clock_control_two_r : `CCSR_ZERO8;
  assign pos_index = hitp1 ? 2'h1 : (hitp2 ? 2'h2 : 2'h0);

  // Polarity is applied before edge detection, so inversion moves the edge.
  wire logic pulse_pol = align_pulse_in ^
    clock_control_one_r[`CCSR_BIT_INVERT];
  // Events pass only with both receiver and processor enabled.
  wire logic event_nxt = pulse_pol & ~pulse_d_r &
    clock_control_zero_r[`CCSR_BIT_PROC_EN] &
    clock_control_zero_r[`CCSR_BIT_RECV_EN];

  ccsr_pos_store u_pos (
    .clk(clk),
    .rst(rst),
    .cap_valid(pos_capture_valid),
    .cap_value(pos_capture_value),
    .rd_index(pos_index),
    .rd_byte(pos_byte)
  );

  // Reserved bits are stored as written; software keeps them default.
  wire logic wr0 = reg_wr & hit0;
  wire logic wr1 = reg_wr & hit1;
  wire logic wr2 = reg_wr & hit2;

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_control_zero_r <= `CCSR_RST_CTRL0;
    end else if (wr0) begin
      clock_control_zero_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_control_one_r <= `CCSR_RST_CTRL1;
    end else if (wr1) begin
      clock_control_one_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_control_two_r <= `CCSR_RST_CTRL2;
    end else if (wr2) begin
      clock_control_two_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_rdata_r <= `CCSR_ZERO8;
      pos_sel_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      ctrl_rdata_r <= ctrl_sel;
      pos_sel_r <= reg_rd & hit_pos;
      rvalid_r <= reg_rd;
    end
  end

  // The edge memory follows the pin even while disabled, so enabling
  // the processor while the pulse is high raises no false event.
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_d_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      pulse_d_r <= pulse_pol;
      event_r <= event_nxt;
    end
  end

  // Both sources are registered, so the final mux needs one more flop.
  wire ccsr_pkg::ccsr_byte_t rdata_nxt =
    pos_sel_r ? pos_byte : ctrl_rdata_r;
  // Control outputs leave reset holding the bits of the reset image.
  wire ccsr_pkg::ccsr_byte_t ctrl0_init = `CCSR_RST_CTRL0;
  wire ccsr_pkg::ccsr_byte_t ctrl1_init = `CCSR_RST_CTRL1;
  wire ccsr_pkg::ccsr_byte_t ctrl2_init = `CCSR_RST_CTRL2;
  wire logic recv_en_nxt =
    clock_control_zero_r[`CCSR_BIT_RECV_EN];
  wire logic proc_en_nxt =
    clock_control_zero_r[`CCSR_BIT_PROC_EN];
  wire logic fine_nxt =
    clock_control_zero_r[`CCSR_BIT_FINE];
  wire ccsr_pkg::ccsr_sel_t sel_nxt =
    clock_control_zero_r[`CCSR_SEL_HI:`CCSR_SEL_LO];
  wire logic invert_nxt =
    clock_control_one_r[`CCSR_BIT_INVERT];
  wire logic dev_pecl_nxt =
    clock_control_one_r[`CCSR_BIT_DEV_PECL];
  wire logic align_pecl_nxt =
    clock_control_one_r[`CCSR_BIT_ALIGN_PECL];
  wire logic ana_suppr_nxt =
    clock_control_two_r[`CCSR_BIT_ANA_SUPPR];
  wire logic clk_suppr_nxt =
    clock_control_two_r[`CCSR_BIT_CLK_SUPPR];

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= `CCSR_ZERO8;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      align_receiver_enable <= ctrl0_init[`CCSR_BIT_RECV_EN];
      align_processor_enable <= ctrl0_init[`CCSR_BIT_PROC_EN];
      align_window_fine_steps <= ctrl0_init[`CCSR_BIT_FINE];
      align_delay_select <= ctrl0_init[`CCSR_SEL_HI:`CCSR_SEL_LO];
    end else begin
      align_receiver_enable <= recv_en_nxt;
      align_processor_enable <= proc_en_nxt;
      align_window_fine_steps <= fine_nxt;
      align_delay_select <= sel_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      align_polarity_invert <= ctrl1_init[`CCSR_BIT_INVERT];
      device_clock_pecl_mode <= ctrl1_init[`CCSR_BIT_DEV_PECL];
      align_input_pecl_mode <= ctrl1_init[`CCSR_BIT_ALIGN_PECL];
    end else begin
      align_polarity_invert <= invert_nxt;
      device_clock_pecl_mode <= dev_pecl_nxt;
      align_input_pecl_mode <= align_pecl_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      analog_rail_noise_suppress <= ctrl2_init[`CCSR_BIT_ANA_SUPPR];
      clock_rail_noise_suppress <= ctrl2_init[`CCSR_BIT_CLK_SUPPR];
    end else begin
      analog_rail_noise_suppress <= ana_suppr_nxt;
      clock_rail_noise_suppress <= clk_suppr_nxt;
    end
  end

  // A second flop stage aligns read data and valid on the same cycle.
  logic rvalid_d_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_d_r <= 1'b0;
    end else begin
      rvalid_d_r <= rvalid_r;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_d_r;
  assign align_event = event_r;
endmodule : ccsr_regs

//--- verif/ccsr_regs_checker.sv
// Purpose: Port assertions for the clock control bank.
// Assumes: Writes reach the outputs two edges later.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ns
`include "ccsr_cfg.svh"
module ccsr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`CCSR_ADDR_W-1:0] reg_addr,
  input wire ccsr_pkg::ccsr_byte_t reg_wdata,
  input wire ccsr_pkg::ccsr_byte_t reg_rdata,
  input wire logic reg_rvalid,
  // Controls
  input wire logic align_event,
  input wire logic align_receiver_enable,
  input wire logic align_processor_enable,
  input wire logic align_window_fine_steps,
  input wire ccsr_pkg::ccsr_sel_t align_delay_select,
  input wire logic align_polarity_invert,
  input wire logic analog_rail_noise_suppress
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire w0 = reg_wr && reg_addr == `CCSR_OFS_CTRL0;
  wire w1 = reg_wr && reg_addr == `CCSR_OFS_CTRL1;
  wire w2 = reg_wr && reg_addr == `CCSR_OFS_CTRL2;
  wire hole = reg_addr < `CCSR_OFS_CTRL0 || reg_addr > `CCSR_OFS_POS2;
  sequence s_proc_off;
    !align_processor_enable ##1 !align_processor_enable;
  endsequence
  a_read_valid_lat: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read valid late");
  a_hole_reads_zero: assert property (reg_rd && hole |->
    ##2 reg_rdata == `CCSR_ZERO8) else $error("unmapped read not zero");
  a_proc_en_follow: assert property (w0 |-> ##2
    align_processor_enable == $past(reg_wdata[6], 2)) else $error("proc");
  a_recv_en_follow: assert property (w0 |-> ##2
    align_receiver_enable == $past(reg_wdata[5], 2)) else $error("recv");
  a_delay_sel_follow: assert property (w0 |-> ##2
    {align_window_fine_steps, align_delay_select} == $past(reg_wdata[4:0], 2))
    else $error("delay select");
  a_invert_follow: assert property (w1 |-> ##2
    align_polarity_invert == $past(reg_wdata[0], 2)) else $error("invert");
  a_ana_suppr_follow: assert property (w2 |-> ##2
    analog_rail_noise_suppress == $past(reg_wdata[2], 2)) else $error("ana");
  a_event_gated: assert property (s_proc_off |-> !align_event)
    else $error("event while processor off");
  a_reset_quiet: assert property ($fell(rst) |-> !align_event &&
    !align_processor_enable && !align_receiver_enable) else $error("reset");
endmodule : ccsr_checker
bind ccsr_regs ccsr_checker u_chk (
  .clk(clk),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .align_event(align_event),
  .align_receiver_enable(align_receiver_enable),
  .align_processor_enable(align_processor_enable),
  .align_window_fine_steps(align_window_fine_steps),
  .align_delay_select(align_delay_select),
  .align_polarity_invert(align_polarity_invert),
  .analog_rail_noise_suppress(analog_rail_noise_suppress)
);

//--- verif/ccsr_regs_test.sv
// Purpose: Self-checking bench for the clock control bank.
// Assumes: Inputs change on the falling edge.
// Notes: Event checks keep the pulse high while polarity flips.
`timescale 1ns/1ns
`include "ccsr_cfg.svh"
module clock_sysref_control_regs_test;
  logic clk, rst, reg_wr, reg_rd, align_pulse_in, pos_capture_valid;
  logic [`CCSR_ADDR_W-1:0] reg_addr;
  ccsr_pkg::ccsr_byte_t reg_wdata, reg_rdata;
  ccsr_pkg::ccsr_pos_t pos_capture_value;
  ccsr_pkg::ccsr_sel_t align_delay_select;
  logic reg_rvalid, align_event, align_receiver_enable, align_processor_enable;
  logic align_window_fine_steps, align_polarity_invert, device_clock_pecl_mode;
  logic align_input_pecl_mode, analog_rail_noise_suppress;
  logic clock_rail_noise_suppress;
  int n_mismatch, samples_checked;
  logic [23:0] tab [3] = '{24'ha0_0715, 24'hf9_0211, 24'he0_0114};
  logic [23:0] v;
  logic [11:0] e12;
  wire [11:0] outs = {align_receiver_enable, align_processor_enable,
    align_window_fine_steps, align_delay_select, align_polarity_invert,
    device_clock_pecl_mode, align_input_pecl_mode,
    analog_rail_noise_suppress, clock_rail_noise_suppress};
  ccsr_regs u_dut (
    .clk(clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .align_pulse_in(align_pulse_in),
    .pos_capture_valid(pos_capture_valid),
    .pos_capture_value(pos_capture_value),
    .align_event(align_event),
    .align_receiver_enable(align_receiver_enable),
    .align_processor_enable(align_processor_enable),
    .align_window_fine_steps(align_window_fine_steps),
    .align_delay_select(align_delay_select),
    .align_polarity_invert(align_polarity_invert),
    .device_clock_pecl_mode(device_clock_pecl_mode),
    .align_input_pecl_mode(align_input_pecl_mode),
    .analog_rail_noise_suppress(analog_rail_noise_suppress),
    .clock_rail_noise_suppress(clock_rail_noise_suppress)
  );
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    int k;
    @(negedge clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 0;
    for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) @(negedge clk);
    chk({3'h0, reg_rvalid, reg_rdata}, {3'h0, 1'b1, e});
  endtask : rd
  task automatic pe(input logic lv, input logic e);
    logic s;
    s = 0;
    @(negedge clk);
    align_pulse_in = lv;
    repeat (4) begin
      @(negedge clk);
      s = s | align_event;
    end
    chk({11'h000, s}, {11'h000, e});
  endtask : pe
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    {rst, reg_wr, reg_rd, align_pulse_in, pos_capture_valid} = 5'h10;
    reg_addr = 15'h0000;
    reg_wdata = 8'h00;
    pos_capture_value = 24'h12_3456;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(negedge clk);
    rst = 0;
    chk(outs, 12'h000);
    rd(15'h0029, 8'h80);
    rd(15'h002a, 8'h00);
    rd(15'h002b, 8'h10);
    rd(15'h002e, 8'h00);
    $display("reset test done");
    wr(15'h002f, 8'hff);
    rd(15'h002f, 8'h00);
    wr(15'h002c, 8'hff);
    rd(15'h002c, 8'h00);
    @(negedge clk);
    pos_capture_valid = 1;
    @(negedge clk);
    pos_capture_valid = 0;
    rd(15'h002c, 8'h56);
    rd(15'h002d, 8'h34);
    rd(15'h002e, 8'h12);
    $display("status test done");
    foreach (tab[i]) begin
      v = tab[i];
      wr(15'h0029, v[23:16]);
      wr(15'h002a, v[15:8]);
      wr(15'h002b, v[7:0]);
      repeat (2) @(negedge clk);
      e12 = {v[21], v[22], v[20:16], v[8], v[10], v[9], v[2], v[0]};
      chk(outs & 12'hfe0, e12 & 12'hfe0);
      chk(outs & 12'h01c, e12 & 12'h01c);
      chk(outs & 12'h003, e12 & 12'h003);
      rd(15'h0029, v[23:16]);
      rd(15'h002a, v[15:8]);
      rd(15'h002b, v[7:0]);
    end
    $display("control test done");
    wr(15'h0029, 8'ha0);
    wr(15'h002a, 8'h00);
    pe(1, 0);
    pe(0, 0);
    wr(15'h0029, 8'he0);
    pe(1, 1);
    wr(15'h002a, 8'h01);
    pe(0, 1);
    pe(1, 0);
    $display("event test done");
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    chk(outs, 12'h000);
    rd(15'h0029, 8'h80);
    rd(15'h002b, 8'h10);
    rd(15'h002c, 8'h00);
    $display("second reset test done");
    conclude();
  end
endmodule : clock_sysref_control_regs_test
